// *** hdl/fip_top.sv ***
`timescale 1ns/10ps
`include "fip_regs.svh"
module fip_top
  import fip_pkg::*;
(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  input  wire logic        I_CE,
  input  wire logic [7:0]  I_SFR_ADDR,
  input  wire logic [7:0]  I_SFR_WDATA,
  input  wire logic        I_SFR_WR,
  input  wire logic        I_SFR_RD,
  output      logic [7:0]  O_SFR_RDATA,
  input  wire logic [14:0] I_IRQ_FLAGS,
  output      logic        O_IRQ_REQ,
  output      logic [3:0]  O_IRQ_ID,
  output      logic [1:0]  O_IRQ_LVL,
  input  wire logic        I_IRQ_ACK,
  input  wire logic        I_IRQ_RETI,
  output      logic [3:0]  O_IN_SERVICE
);

  fip_state_t  r;
  fip_state_t  next_r;
  fip_if       u_if ();
  logic [14:0] src_en;
  logic [2:0]  svc_top;

  fip_arb u_arb (
    .bus (u_if)
  );

  // highest level in service, bit 2 flags that any level is in service
  function automatic logic [2:0] top_level(input logic [3:0] a);
    top_level = 3'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (a[i])
        top_level = {1'b1, 2'(i)};
    end
  endfunction

  assign u_if.clk   = I_CLK_SYS;
  assign u_if.rst_n = I_RST_N;
  assign src_en     = {r.en_b, r.en_a[`FIP_SRC_TOP:0]};
  assign svc_top    = top_level(r.active);
  assign u_if.pend  = I_IRQ_FLAGS & src_en & {15{r.en_a[`FIP_GEN_BIT]}};
  assign u_if.hi   = {r.phi_b, r.phi_a[`FIP_SRC_TOP:0]};
  assign u_if.lo   = {r.plo_b, r.plo_a[`FIP_SRC_TOP:0]};

  always_comb
  begin
    logic [2:0] top;
    top    = 3'h0;
    next_r = r;
    if (I_SFR_WR)
    begin
      unique case (I_SFR_ADDR)
        `FIP_ADDR_EN_A:  next_r.en_a  = I_SFR_WDATA;
        `FIP_ADDR_EN_B:  next_r.en_b  = I_SFR_WDATA;
        `FIP_ADDR_PHI_A: next_r.phi_a = I_SFR_WDATA & `FIP_MASK_A;
        `FIP_ADDR_PLO_A: next_r.plo_a = I_SFR_WDATA & `FIP_MASK_A;
        `FIP_ADDR_PLO_B: next_r.plo_b = I_SFR_WDATA;
        `FIP_ADDR_PHI_B: next_r.phi_b = I_SFR_WDATA;
        default:         next_r.en_a  = r.en_a;
      endcase
    end
    // other addresses belong to other blocks, so they read as zero here
    next_r.rdata = `FIP_RST_BYTE;
    if (I_SFR_RD)
    begin
      unique case (I_SFR_ADDR)
        `FIP_ADDR_EN_A:  next_r.rdata = r.en_a;
        `FIP_ADDR_EN_B:  next_r.rdata = r.en_b;
        `FIP_ADDR_PHI_A: next_r.rdata = r.phi_a;
        `FIP_ADDR_PLO_A: next_r.rdata = r.plo_a;
        `FIP_ADDR_PLO_B: next_r.rdata = r.plo_b;
        `FIP_ADDR_PHI_B: next_r.rdata = r.phi_b;
        default:         next_r.rdata = `FIP_RST_BYTE;
      endcase
    end
    // return first, so an ack in the same cycle nests on the resumed level
    top = top_level(r.active);
    if (I_IRQ_RETI && top[2])
      next_r.active = r.active & ~(4'h1 << top[1:0]);
    if (I_IRQ_ACK && r.req)
      next_r.active = next_r.active | (4'h1 << r.lvl);
    // compare against the updated stack, so a just-taken source cannot ask again
    top          = top_level(next_r.active);
    next_r.req   = u_if.vld && (!top[2] || u_if.lvl > top[1:0]);
    next_r.id    = u_if.id;
    next_r.lvl   = u_if.lvl;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
      r <= '0;
    else if (I_CE)
      r <= next_r;
  end

  assign O_SFR_RDATA  = r.rdata;
  assign O_IRQ_REQ    = r.req;
  assign O_IRQ_ID     = r.id;
  assign O_IRQ_LVL    = r.lvl;
  assign O_IN_SERVICE = r.active;

  sequence s_wr(logic [7:0] a);
    I_CE && I_SFR_WR && I_SFR_ADDR == a;
  endsequence

  property p_store(logic [7:0] a, logic [7:0] q, logic [7:0] m);
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_wr(a) |=> q == ($past(I_SFR_WDATA) & m);
  endproperty

  sequence s_take;
    I_CE && I_IRQ_ACK && O_IRQ_REQ && !I_IRQ_RETI;
  endsequence

  sequence s_ret;
    I_CE && I_IRQ_RETI && !I_IRQ_ACK && svc_top[2];
  endsequence

  sequence s_rd(logic [7:0] a);
    I_CE && I_SFR_RD && I_SFR_ADDR == a;
  endsequence

  property p_read(logic [7:0] a, logic [7:0] q);
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_rd(a) |=> O_SFR_RDATA == $past(q);
  endproperty

  chk_low_a_store: assert property (p_store(`FIP_ADDR_PLO_A, r.plo_a, `FIP_MASK_A))
    else $error("low priority register A did not store");
  chk_high_a_store: assert property (p_store(`FIP_ADDR_PHI_A, r.phi_a, `FIP_MASK_A))
    else $error("high priority register A did not store");
  chk_low_b_store: assert property (p_store(`FIP_ADDR_PLO_B, r.plo_b, `FIP_MASK_B))
    else $error("low priority register B did not store");
  chk_high_b_store: assert property (p_store(`FIP_ADDR_PHI_B, r.phi_b, `FIP_MASK_B))
    else $error("high priority register B did not store");

  chk_low_a_read: assert property (p_read(`FIP_ADDR_PLO_A, r.plo_a))
    else $error("low priority register A read back wrong");
  chk_high_a_read: assert property (p_read(`FIP_ADDR_PHI_A, r.phi_a))
    else $error("high priority register A read back wrong");
  chk_low_b_read: assert property (p_read(`FIP_ADDR_PLO_B, r.plo_b))
    else $error("low priority register B read back wrong");
  chk_high_b_read: assert property (p_read(`FIP_ADDR_PHI_B, r.phi_b))
    else $error("high priority register B read back wrong");

  chk_enable_gate: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    u_if.vld |-> I_IRQ_FLAGS[u_if.id] && src_en[u_if.id] && r.en_a[`FIP_GEN_BIT])
    else $error("grant to a disabled source");
  chk_no_winner: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    I_CE && !u_if.vld |=> !O_IRQ_REQ)
    else $error("request with no enabled source pending");
  chk_global_off: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    I_CE && !r.en_a[`FIP_GEN_BIT] |=> !O_IRQ_REQ)
    else $error("request while global enable is off");
  chk_req_follows: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    I_CE && u_if.vld && !svc_top[2] && !I_IRQ_ACK && !I_IRQ_RETI |=> O_IRQ_REQ && O_IRQ_ID == $past(u_if.id))
    else $error("idle request does not follow the winner");
  // the stack and the request come from one edge, so the compare needs no history
  chk_preempt_only: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_IRQ_REQ |-> r.active == `FIP_NO_ACTIVE || O_IRQ_LVL > svc_top[1:0])
    else $error("request does not outrank the service in progress");
  chk_ack_nest: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_take |=> O_IN_SERVICE[$past(O_IRQ_LVL)] && (!O_IRQ_REQ || O_IRQ_LVL > $past(O_IRQ_LVL)))
    else $error("ack did not enter service at the granted level");
  chk_reti_pop: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_ret |=> O_IN_SERVICE == ($past(O_IN_SERVICE) & ~(4'h1 << $past(svc_top[1:0]))))
    else $error("return did not end the innermost service");

endmodule

// *** hdl/fip_regs.svh ***
`ifndef FIP_REGS_SVH
`define FIP_REGS_SVH

// register addresses
`define FIP_ADDR_EN_A    8'hA8
`define FIP_ADDR_EN_B    8'hE8
`define FIP_ADDR_PHI_A   8'hB7
`define FIP_ADDR_PLO_A   8'hB8
`define FIP_ADDR_PLO_B   8'hF8
`define FIP_ADDR_PHI_B   8'hF7

// field positions
`define FIP_GEN_BIT      7
`define FIP_SRC_TOP      6

// reset and write masks
`define FIP_RST_BYTE     8'h00
`define FIP_MASK_A       8'h7F
`define FIP_MASK_B       8'hFF
`define FIP_NO_ACTIVE    4'h0

`endif

// *** hdl/fip_pkg.sv ***
package fip_pkg;

  typedef logic [1:0] fip_lvl_t;
  typedef logic [3:0] fip_id_t;

  // source index: 0 ext0, 1 tmr0, 2 ext1, 3 tmr1, 4 uart, 5 twowire, 6 conv,
  // 7..10 capture0..3, 11..13 match0..2, 14 t2 overflow
  typedef fip_id_t fip_order_t [15];

  localparam fip_order_t FIP_ORDER = '{4'h0, 4'h5, 4'h6, 4'h1, 4'h7, 4'hB, 4'h2, 4'h8,
                                        4'hC, 4'h3, 4'h9, 4'hD, 4'h4, 4'hA, 4'hE};

  typedef struct packed {
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] phi_a;
    logic [7:0] plo_a;
    logic [7:0] plo_b;
    logic [7:0] phi_b;
    logic [3:0] active;
    logic       req;
    fip_id_t    id;
    fip_lvl_t   lvl;
    logic [7:0] rdata;
  } fip_state_t;

endpackage

// *** hdl/fip_if.sv ***
`timescale 1ns/10ps
interface fip_if;
  import fip_pkg::*;

  logic        clk;
  logic        rst_n;
  logic [14:0] pend;
  logic [14:0] hi;
  logic [14:0] lo;
  logic        vld;
  fip_id_t     id;
  fip_lvl_t    lvl;

  modport arb (input clk, input rst_n, input pend, input hi, input lo, output vld, output id, output lvl);
  modport ctl (output clk, output rst_n, output pend, output hi, output lo, input vld, input id, input lvl);
endinterface

// *** hdl/fip_arb.sv ***
`timescale 1ns/10ps
module fip_arb
  import fip_pkg::*;
(
  fip_if.arb bus
);

  fip_lvl_t src_lvl [15];
  logic     higher_seen;
  logic     earlier_tie;

  genvar g;
  generate
    for (g = 0; g < 15; g++)
    begin : g_lvl
      assign src_lvl[g] = {bus.hi[g], bus.lo[g]};
    end
  endgenerate

  // strict compare lets the earlier entry of the fixed order keep a tie
  always_comb
  begin
    bus.vld = 1'b0;
    bus.id  = 4'h0;
    bus.lvl = 2'h0;
    for (int k = 0; k < 15; k++)
    begin
      if (bus.pend[FIP_ORDER[k]] && (!bus.vld || src_lvl[FIP_ORDER[k]] > bus.lvl))
      begin
        bus.vld = 1'b1;
        bus.id  = FIP_ORDER[k];
        bus.lvl = src_lvl[FIP_ORDER[k]];
      end
    end
  end

  // helper for checking only
  always_comb
  begin
    higher_seen = 1'b0;
    earlier_tie = 1'b0;
    for (int k = 0; k < 15; k++)
    begin
      if (bus.pend[FIP_ORDER[k]] && src_lvl[FIP_ORDER[k]] > bus.lvl)
        higher_seen = 1'b1;
    end
    for (int k = 0; k < 15; k++)
    begin
      if (FIP_ORDER[k] == bus.id)
        break;
      if (bus.pend[FIP_ORDER[k]] && src_lvl[FIP_ORDER[k]] == bus.lvl)
        earlier_tie = 1'b1;
    end
  end

  chk_highest_level: assert property (@(posedge bus.clk) disable iff (!bus.rst_n)
    bus.vld |-> !higher_seen)
    else $error("grant is not at the highest pending level");
  chk_tie_order: assert property (@(posedge bus.clk) disable iff (!bus.rst_n)
    bus.vld |-> !earlier_tie)
    else $error("grant skips an earlier source of the same level");
  chk_level_map: assert property (@(posedge bus.clk) disable iff (!bus.rst_n)
    bus.vld |-> bus.lvl == {bus.hi[bus.id], bus.lo[bus.id]})
    else $error("grant level does not match priority bits");

endmodule

// *** sim/fip_core_model.sv ***
`timescale 1ns/10ps
// core side: takes a request only while it stands, after a prompt or slow delay
module fip_core_model
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_req,
  input  wire logic i_take,
  input  wire logic i_slow,
  input  wire logic i_ret,
  output      logic o_ack,
  output      logic o_reti
);
  logic [1:0] cnt;

  // ack guard stops a second take while the dropped request is still visible
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt    <= 2'h0;
      o_ack  <= 1'b0;
      o_reti <= 1'b0;
    end
    else
    begin
      o_reti <= i_ret & ~o_reti;
      o_ack  <= 1'b0;
      cnt    <= 2'h0;
      if (i_take && i_req && !o_ack)
      begin
        if (cnt >= (i_slow ? 2'h3 : 2'h0))
          o_ack <= 1'b1;
        else
          cnt <= cnt + 2'h1;
      end
    end
  end
endmodule

// *** sim/fip_top_tb.sv ***
`timescale 1ns/10ps
`include "fip_regs.svh"
module fip_top_tb
  import fip_pkg::*;
;
  logic        clk, rst_n, wr, rd, take, slow, ret, ack, reti, req;
  logic [7:0]  addr, wdata, rdata;
  logic [14:0] flags;
  logic [3:0]  id, in_svc;
  logic [1:0]  lvl;
  int          fail_count, n_compared, cyc;

  fip_top i_fip_top (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CE(1'b1), .I_SFR_ADDR(addr), .I_SFR_WDATA(wdata),
    .I_SFR_WR(wr), .I_SFR_RD(rd), .O_SFR_RDATA(rdata), .I_IRQ_FLAGS(flags), .O_IRQ_REQ(req), .O_IRQ_ID(id),
    .O_IRQ_LVL(lvl), .I_IRQ_ACK(ack), .I_IRQ_RETI(reti), .O_IN_SERVICE(in_svc));
  fip_core_model i_fip_core_model (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_take(take), .i_slow(slow),
    .i_ret(ret), .o_ack(ack), .o_reti(reti));

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 chk("register read", e, rdata);
  endtask
  task irq(input string nm, input logic r, input fip_id_t i, input fip_lvl_t l);
    repeat (2) @(posedge clk);
    #1 chk(nm, {1'b0, r, i, l}, {1'b0, req, id, lvl});
  endtask
  task serve(input logic s, input logic [3:0] e_svc);
    int n;
    @(posedge clk); take <= 1'b1; slow <= s; n = 0;
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    take <= 1'b0;
    #1 chk("in service", {4'h0, e_svc}, {4'h0, in_svc});
  endtask
  task retire();
    @(posedge clk); ret <= 1'b1;
    @(posedge clk); ret <= 1'b0;
  endtask
  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task t_regs();
    logic [7:0] a [7] = '{`FIP_ADDR_EN_A, `FIP_ADDR_EN_B, `FIP_ADDR_PHI_A, `FIP_ADDR_PLO_A, `FIP_ADDR_PLO_B,
                          `FIP_ADDR_PHI_B, 8'h55};
    logic [7:0] m [7] = '{8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'h00};
    for (int i = 0; i < 7; i++) rreg(a[i], 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      wreg(a[i], 8'hFF);
      rreg(a[i], m[i]);
      wreg(a[i], 8'h00);
    end
  endtask
  task t_enable();
    @(posedge clk); flags <= 15'h0001;
    wreg(`FIP_ADDR_PLO_A, 8'h01);
    wreg(`FIP_ADDR_EN_A, 8'h01);
    irq("global off", 1'b0, 4'h0, 2'h0);
    wreg(`FIP_ADDR_EN_A, 8'h80);
    irq("source off", 1'b0, 4'h0, 2'h0);
    wreg(`FIP_ADDR_EN_A, 8'h81);
    irq("source on", 1'b1, 4'h0, 2'h1);
    wreg(`FIP_ADDR_PLO_A, 8'h00);
  endtask
  task t_order();
    wreg(`FIP_ADDR_EN_A, 8'hFF);
    wreg(`FIP_ADDR_EN_B, 8'hFF);
    @(posedge clk); flags <= 15'h7FFF;
    for (int k = 0; k < 15; k++)
    begin
      irq("tie order", 1'b1, FIP_ORDER[k], 2'h0);
      @(posedge clk); flags[FIP_ORDER[k]] <= 1'b0;
    end
    irq("all served", 1'b0, 4'h0, 2'h0);
  endtask
  task t_level();
    // t2 overflow is last in the tie order, so only its level can lift it above ext0
    @(posedge clk); flags <= 15'h4001;
    for (int l = 0; l < 4; l++)
    begin
      wreg(`FIP_ADDR_PHI_B, l >= 2 ? 8'h80 : 8'h00);
      wreg(`FIP_ADDR_PLO_B, l[0] ? 8'h80 : 8'h00);
      irq("level", 1'b1, l == 0 ? 4'h0 : 4'hE, fip_lvl_t'(l));
    end
    wreg(`FIP_ADDR_PHI_A, 8'h01);
    wreg(`FIP_ADDR_PLO_A, 8'h01);
    irq("tie at top", 1'b1, 4'h0, 2'h3);
    @(posedge clk); flags <= 15'h0000;
    wreg(`FIP_ADDR_PHI_B, 8'h00);
    wreg(`FIP_ADDR_PLO_B, 8'h00);
  endtask
  task t_nest();
    wreg(`FIP_ADDR_PHI_A, 8'h02);
    @(posedge clk); flags <= 15'h0004;
    irq("level 0 request", 1'b1, 4'h2, 2'h0);
    serve(1'b0, 4'h1);
    @(posedge clk); flags <= 15'h0005;
    irq("preempt", 1'b1, 4'h0, 2'h1);
    serve(1'b1, 4'h3);
    irq("equal held", 1'b0, 4'h0, 2'h1);
    @(posedge clk); flags <= 15'h0007;
    irq("higher preempts", 1'b1, 4'h1, 2'h2);
    @(posedge clk); flags <= 15'h0004;
    retire();
    irq("lower held", 1'b0, 4'h2, 2'h0);
    chk("in service", 8'h01, {4'h0, in_svc});
    retire();
    irq("resume", 1'b1, 4'h2, 2'h0);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      finish_test();
    end
  end
  initial
  begin
    {rst_n, wr, rd, take, slow, ret, addr, wdata, flags} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_enable();
    t_order();
    t_level();
    t_nest();
    finish_test();
  end
endmodule
